// file: include/tsil_pkg.sv
// package of constants for the touch-state interrupt logic
package tsil_pkg;

  // ------------------------------------------------------------
  // register map (word-aligned byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_SENSE = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_LATCH_BIT = 2;
  localparam int CFG_KEY_LSB = 3;
  localparam int CFG_MSK_BIT = 5;
  localparam int CFG_INTSEL_BIT = 6;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;

  localparam logic [1:0] MODE_STANDALONE = 2'h0;
  localparam logic [1:0] MODE_PRIMARY = 2'h1;
  localparam logic [1:0] MODE_SECONDARY = 2'h2;
  localparam logic [1:0] KEY_N = 2'h0;
  localparam logic [1:0] KEY_ONE = 2'h1;
  localparam logic [1:0] KEY_TWO = 2'h2;

  // ------------------------------------------------------------
  // commands written to the command register
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_SLEEP = 8'h01;
  localparam logic [7:0] CMD_WAKE = 8'h02;
  localparam logic [7:0] CMD_CLEAR_IRQ = 8'h03;

  // ------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_READY_LSB = 8;

  // fast start-up length in sample ticks
  localparam int FAST_START_TICKS = 16;

endpackage : tsil_pkg

// file: hdl/tsil_core.sv
// touch-state and interrupt logic with a wishbone register slave
`timescale 1ns/1ps
module tsil_core #(
  parameter int CHANNELS = 8,
  parameter int FAST_TICKS = tsil_pkg::FAST_START_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [CHANNELS-1:0] channelDetectFlag,
  input wire logic sleepPin,
  input wire logic cascadeClkIn,
  input wire logic oscTick,
  output logic oscEnable,
  output logic cascadeClkOut,
  output logic regulatorEnable,
  output logic analogEnable,
  output logic [CHANNELS-1:0] sampleEnable,
  output logic [CHANNELS-1:0] fastStart,
  output logic sampleTick,
  output logic irqOutLow
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] detMeta_q, det_q;
  logic [2:0] pinMeta_q, pin_q;

  always_ff @(posedge clk) begin
    detMeta_q <= channelDetectFlag;
    det_q <= detMeta_q;
    pinMeta_q <= {sleepPin, cascadeClkIn, oscTick};
    pin_q <= pinMeta_q;
  end

  logic sleepPinS, casClkS, oscS;
  assign sleepPinS = pin_q[2];
  assign casClkS = pin_q[1];
  assign oscS = pin_q[0];

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic [6:0] config_q;
  logic [CHANNELS-1:0] mask_q;
  logic [CHANNELS-1:0] sense_q;
  logic [CHANNELS-1:0] ready_q;
  logic sleepCmd_q, irq_q, ack_q, err_q;
  logic [31:0] rdata_q;

  logic req, hit, wrCfg, wrMask, wrCmd, rdSense;
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;

  function automatic logic mapped(input logic [7:0] a);
    return a == tsil_pkg::ADDR_CONFIG || a == tsil_pkg::ADDR_MASK ||
           a == tsil_pkg::ADDR_SENSE || a == tsil_pkg::ADDR_COMMAND ||
           a == tsil_pkg::ADDR_STATUS;
  endfunction : mapped

  assign hit = req && mapped(wb_adr_i);
  assign wrCfg = hit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == tsil_pkg::ADDR_CONFIG;
  assign wrMask = hit && wb_we_i && wb_sel_i[0] &&
                  wb_adr_i == tsil_pkg::ADDR_MASK;
  assign wrCmd = hit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == tsil_pkg::ADDR_COMMAND;
  assign rdSense = hit && !wb_we_i && wb_adr_i == tsil_pkg::ADDR_SENSE;

  // ------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------
  logic [1:0] mainModeSelect, keyMode;
  logic latching, maskedSamplingSelect, interruptEventSelect;
  assign mainModeSelect = config_q[tsil_pkg::CFG_MODE_LSB +: 2];
  assign latching = config_q[tsil_pkg::CFG_LATCH_BIT];
  assign keyMode = config_q[tsil_pkg::CFG_KEY_LSB +: 2];
  assign maskedSamplingSelect = config_q[tsil_pkg::CFG_MSK_BIT];
  assign interruptEventSelect = config_q[tsil_pkg::CFG_INTSEL_BIT];

  // direct switching and N-key come from reset value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_q <= tsil_pkg::CONFIG_RESET;
    end else if (wrCfg) begin
      config_q <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= tsil_pkg::MASK_RESET[CHANNELS-1:0];
    end else if (wrMask) begin
      mask_q <= wb_dat_i[CHANNELS-1:0];
    end
  end

  // ------------------------------------------------------------
  // sleep control
  // ------------------------------------------------------------
  // command sets, wake clears; pin forces sleep while high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleepCmd_q <= 1'b0;
    end else if (wrCmd && wb_dat_i[7:0] == tsil_pkg::CMD_SLEEP) begin
      sleepCmd_q <= 1'b1;
    end else if (wrCmd && wb_dat_i[7:0] == tsil_pkg::CMD_WAKE) begin
      sleepCmd_q <= 1'b0;
    end
  end

  logic asleep;
  // pin falling wakes only when no command sleep is pending
  assign asleep = sleepCmd_q || sleepPinS;

  // power-down of analogue, oscillator and regulator
  assign oscEnable = !asleep && mainModeSelect != tsil_pkg::MODE_SECONDARY;
  assign regulatorEnable = !asleep;
  assign analogEnable = !asleep;

  // ------------------------------------------------------------
  // sample clock
  // ------------------------------------------------------------
  logic clkSrc, clkSrcPrev_q;
  // inverted cascade clock in secondary mode
  assign clkSrc = (mainModeSelect == tsil_pkg::MODE_SECONDARY) ?
                  !casClkS : oscS;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkSrcPrev_q <= 1'b0;
    end else begin
      clkSrcPrev_q <= clkSrc;
    end
  end

  logic tick;
  assign tick = !asleep && clkSrc && !clkSrcPrev_q;

  // cascade clock out only in primary mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cascadeClkOut <= 1'b0;
    end else begin
      cascadeClkOut <= !asleep && oscS &&
                       mainModeSelect == tsil_pkg::MODE_PRIMARY;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= tick;
    end
  end

  // ------------------------------------------------------------
  // per-channel sampling and fast start-up
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] sampled;
  // sequencer skips disabled channels, else all
  assign sampled = maskedSamplingSelect ? mask_q : {CHANNELS{1'b1}};

  logic [CHANNELS-1:0] maskPrev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      maskPrev_q <= '0;
    end else begin
      maskPrev_q <= sampled;
    end
  end

  localparam int FW = $clog2(FAST_TICKS + 1);
  logic [CHANNELS-1:0][FW-1:0] fastCnt_q;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gChan
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          fastCnt_q[g] <= FW'(FAST_TICKS);
        end else if (asleep) begin
          fastCnt_q[g] <= FW'(FAST_TICKS);
        // unsampled channel waits full, never ready on enable
        end else if (!sampled[g]) begin
          fastCnt_q[g] <= FW'(FAST_TICKS);
        end else if (sampled[g] && !maskPrev_q[g]) begin
          fastCnt_q[g] <= FW'(FAST_TICKS);
        end else if (tick && sampled[g] && fastCnt_q[g] != '0) begin
          fastCnt_q[g] <= fastCnt_q[g] - FW'(1);
        end
      end
      assign ready_q[g] = fastCnt_q[g] == '0;
      assign fastStart[g] = !ready_q[g] && sampled[g] && !asleep;
      assign sampleEnable[g] = sampled[g] && !asleep;
    end
  endgenerate

  // ------------------------------------------------------------
  // sensor-state word
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] active;
  // disabled or not yet operational channels are ignored
  assign active = det_q & mask_q & ready_q;

  logic [CHANNELS-1:0] accepted_q;
  logic [CHANNELS-1:0] allowed, newSet, senseD;
  logic [3:0] accCnt;
  always_comb begin
    accCnt = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      accCnt = accCnt + {3'b0, accepted_q[i]};
    end
  end

  // filter: which channels may newly set their bit this cycle
  always_comb begin
    logic [3:0] room;
    room = 4'h0;
    allowed = '0;
    case (keyMode)
      tsil_pkg::KEY_ONE: room = 4'h1 - ((accCnt > 4'h1) ? 4'h1 : accCnt);
      tsil_pkg::KEY_TWO: room = 4'h2 - ((accCnt > 4'h2) ? 4'h2 : accCnt);
      default: room = 4'h8;
    endcase
    for (int i = 0; i < CHANNELS; i++) begin
      if (accepted_q[i] || (active[i] && !sense_q[i] && room != 4'h0)) begin
        allowed[i] = 1'b1;
        if (!accepted_q[i] && keyMode != tsil_pkg::KEY_N) begin
          room = room - 4'h1;
        end
      end
    end
    if (keyMode == tsil_pkg::KEY_N) begin
      allowed = {CHANNELS{1'b1}};
    end
  end

  // blocked channels never reach the state word
  assign newSet = active & allowed & ~sense_q;

  always_comb begin
    if (!latching) begin
      senseD = (sense_q & active) | newSet;
    end else if (rdSense) begin
      // read drops released bits; sets still land
      senseD = (sense_q & active) | newSet;
    end else begin
      senseD = sense_q | newSet;
    end
  end

  // state word of detect flags; kept in sleep only when latching, cleared otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_q <= '0;
    end else begin
      sense_q <= senseD;
    end
  end

  // acceptance ends once the bit leaves the word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accepted_q <= '0;
    end else if (keyMode == tsil_pkg::KEY_N) begin
      accepted_q <= '0;
    end else begin
      accepted_q <= senseD;
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  logic [CHANNELS-1:0] setBits, clrBits;
  logic [3:0] senseCnt;
  logic irqEvent;
  assign setBits = senseD & ~sense_q;
  assign clrBits = sense_q & ~senseD;

  always_comb begin
    senseCnt = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      senseCnt = senseCnt + {3'b0, senseD[i]};
    end
  end

  always_comb begin
    irqEvent = interruptEventSelect ? (setBits != '0) :
               ((setBits | clrBits) != '0);
    // 2-key waits for two bits set
    if (keyMode == tsil_pkg::KEY_TWO && senseCnt < 4'h2) begin
      irqEvent = 1'b0;
    end
    // in 1-key any accepted set raises it, via setBits
  end

  logic irqClr;
  assign irqClr = rdSense ||
                  (wrCmd && wb_dat_i[7:0] == tsil_pkg::CMD_CLEAR_IRQ);

  // read or command clears; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (irqEvent) begin
      irq_q <= 1'b1;
    end else if (irqClr) begin
      irq_q <= 1'b0;
    end
  end

  assign irqOutLow = !irq_q;

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= hit;
      err_q <= req && !hit;
      rdata_q <= '0;
      if (hit && !wb_we_i) begin
        case (wb_adr_i)
          tsil_pkg::ADDR_CONFIG: rdata_q <= {25'h0, config_q};
          tsil_pkg::ADDR_MASK: rdata_q <= 32'(mask_q);
          tsil_pkg::ADDR_SENSE: rdata_q <= 32'(sense_q);
          tsil_pkg::ADDR_STATUS: begin
            rdata_q[tsil_pkg::STAT_SLEEP_BIT] <= asleep;
            rdata_q[tsil_pkg::STAT_IRQ_BIT] <= irq_q;
            rdata_q[tsil_pkg::STAT_READY_LSB +: CHANNELS] <= ready_q;
          end
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

endmodule : tsil_core

// file: sim/tsil_front_end.sv
// sensor front end and cascade clock model for the bench
`timescale 1ns/1ps
module tsil_front_end (
  input wire logic clk,
  input wire logic oscEnable,
  input wire logic [7:0] sampleEnable,
  input wire logic [7:0] touched,
  output logic oscTick,
  output logic cascadeClkIn,
  output logic [7:0] channelDetectFlag
);
  logic [2:0] div_q = 3'h0;
  initial oscTick = 1'b0;
  initial cascadeClkIn = 1'b0;
  // a stopped oscillator holds its level; the primary clock runs free
  always @(posedge clk) begin
    div_q <= div_q + 3'h1;
    if (oscEnable && div_q == 3'h7) begin
      oscTick <= !oscTick;
    end
    if (div_q[1:0] == 2'h3) begin
      cascadeClkIn <= !cascadeClkIn;
    end
  end
  // an unsampled channel has its comparator off and reports no touch
  assign channelDetectFlag = touched & sampleEnable;
endmodule : tsil_front_end

// file: sim/tsil_core_assertions.sv
// assertion checker for the touch-state interrupt logic
`timescale 1ns/1ps
module tsil_core_assertions #(
  parameter int CHANNELS = 8,
  parameter int FAST_TICKS = tsil_pkg::FAST_START_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [CHANNELS-1:0] channelDetectFlag,
  input wire logic sleepPin,
  input wire logic cascadeClkIn,
  input wire logic sampleTick,
  input wire logic oscEnable,
  input wire logic cascadeClkOut,
  input wire logic regulatorEnable,
  input wire logic analogEnable,
  input wire logic [CHANNELS-1:0] sampleEnable,
  input wire logic [CHANNELS-1:0] fastStart,
  input wire logic irqOutLow
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [CHANNELS-1:0] lastFlag_q;
  logic [2:0] quiet_q;
  // a new irq wins over a clear, so clears are judged on quiet inputs only
  always_ff @(posedge clk) begin
    lastFlag_q <= channelDetectFlag;
    if (sys_rst || channelDetectFlag != lastFlag_q) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence clearCmd;
    reqTaken ##0 (wb_we_i && wb_sel_i[0] && wb_dat_i[7:0] ==
      tsil_pkg::CMD_CLEAR_IRQ && wb_adr_i == tsil_pkg::ADDR_COMMAND);
  endsequence
  chk_answer_next: assert property (reqTaken |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered in the next cycle");
  chk_answer_pulse: assert property
    ((wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside an ack");
  chk_sleep_power: assert property (!regulatorEnable |->
    !oscEnable && !analogEnable && !(|sampleEnable))
    else $error("activity left while asleep");
  chk_sleep_bus: assert property (reqTaken ##0 !regulatorEnable |=>
    wb_ack_o || wb_err_o)
    else $error("bus silent while asleep");
  chk_wake_fast: assert property ($rose(regulatorEnable) |->
    fastStart == sampleEnable)
    else $error("wake without fast start");
  chk_enable_fast: assert property (
    !(|(sampleEnable & ~$past(sampleEnable) & ~fastStart)))
    else $error("new channel skipped fast start");
  chk_pin_sleep: assert property (sleepPin [*3] |->
    ##[1:3] !regulatorEnable)
    else $error("sleep pin ignored");
  chk_clkout_gate: assert property (cascadeClkOut |->
    $past(oscEnable) && $past(regulatorEnable))
    else $error("clock out without running oscillator");
  chk_clear_irq: assert property (clearCmd ##0 quiet_q == 3'h7 &&
    !(|fastStart) |=> irqOutLow)
    else $error("clear command left irq pending");
  // sync of the clock input plus the tick register gives three cycles
  chk_secondary_tick: assert property (!oscEnable && regulatorEnable &&
    $fell(cascadeClkIn) |-> ##3 sampleTick)
    else $error("secondary tick not on falling clock input");
endmodule : tsil_core_assertions

bind tsil_core tsil_core_assertions #(
  .CHANNELS(CHANNELS),
  .FAST_TICKS(FAST_TICKS)
) u_chk (
  .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .channelDetectFlag,
  .sleepPin, .cascadeClkIn, .sampleTick,
  .oscEnable, .cascadeClkOut, .regulatorEnable, .analogEnable,
  .sampleEnable, .fastStart, .irqOutLow
);

// file: sim/tb_tsil_core.sv
// self-checking bench for the touch-state interrupt logic
`timescale 1ns/1ps
module tb_tsil_core;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic sleepPin = 1'b0;
  logic [7:0] touched = 8'h00;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, oscEnable, cascadeClkOut, regulatorEnable;
  logic analogEnable, sampleTick, irqOutLow, oscTick, cascadeClkIn;
  logic [7:0] channelDetectFlag, sampleEnable, fastStart, tgt, prev;
  logic [32:0] expQ[$];
  logic [32:0] expE;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 3;
  int ticks = 0;
  int t0;
  int outHigh = 0;
  always #5 clk = !clk;
  tsil_core #(.FAST_TICKS(2)) u_dut (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .channelDetectFlag,
    .sleepPin, .cascadeClkIn, .oscTick, .oscEnable, .cascadeClkOut,
    .regulatorEnable, .analogEnable, .sampleEnable, .fastStart,
    .sampleTick, .irqOutLow
  );
  tsil_front_end u_fe (
    .clk, .oscEnable, .sampleEnable, .touched, .oscTick, .cascadeClkIn,
    .channelDetectFlag
  );
  task automatic chk(input logic [32:0] s, input logic [32:0] e,
                     input string n);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // request is held until the edge that samples the answer
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    expQ.push_back(e);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (!(wb_ack_o || wb_err_o)) @(posedge clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 33'h0);
  endtask : wr
  task automatic rs(input logic [7:0] e);
    bus(1'b0, tsil_pkg::ADDR_SENSE, 32'h0, {25'h0, e});
  endtask : rs
  // flags cross 2 sync flops and the state register
  task automatic touch(input logic [7:0] t);
    touched <= t;
    repeat (6) @(posedge clk);
  endtask : touch
  task automatic mode(input logic [7:0] c);
    touch(8'h00);
    wr(tsil_pkg::ADDR_CONFIG, c);
    wr(tsil_pkg::ADDR_COMMAND, tsil_pkg::CMD_CLEAR_IRQ);
    while (fastStart !== 8'h00) @(posedge clk);
  endtask : mode
  always @(posedge clk) begin
    ticks <= ticks + int'(sampleTick === 1'b1);
    outHigh <= outHigh + int'(cascadeClkOut === 1'b1);
    if (wb_ack_o || wb_err_o) begin
      expE = expQ.pop_front();
      chk({wb_err_o, wb_we_i ? 32'h0 : wb_dat_o},
          wb_we_i ? {expE[32], 32'h0} : expE, "bus");
    end
  end
  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    while (fastStart !== 8'h00) @(posedge clk);
    chk(irqOutLow, 1'b1, "irq idle");
    chk(oscEnable, 1'b1, "osc");
    bus(1'b0, tsil_pkg::ADDR_CONFIG, 32'h0, 33'h0);
    bus(1'b0, tsil_pkg::ADDR_MASK, 32'h0, 33'h0FF);
    bus(1'b0, tsil_pkg::ADDR_STATUS, 32'h0, 33'h0FF00);
    bus(1'b0, 8'h14, 32'h0, 33'h100000000);
    wr(tsil_pkg::ADDR_SENSE, 8'hFF);
    rs(8'h00);
    tgt = 8'h00;
    repeat (6) begin
      prev = tgt;
      tgt = 8'($random(seed));
      touch(tgt);
      chk(irqOutLow, tgt == prev, "irq change");
      rs(tgt);
      chk(irqOutLow, 1'b1, "irq read");
    end
    mode(8'h40);
    chk(irqOutLow, 1'b1, "irq cmd");
    touch(8'h01);
    chk(irqOutLow, 1'b0, "irq set");
    rs(8'h01);
    touch(8'h00);
    chk(irqOutLow, 1'b1, "irq release");
    mode(8'h48);
    touch(8'h04);
    chk(irqOutLow, 1'b0, "one first");
    rs(8'h04);
    touch(8'h0C);
    chk(irqOutLow, 1'b1, "one blocked");
    rs(8'h04);
    touch(8'h00);
    touch(8'h08);
    chk(irqOutLow, 1'b0, "one again");
    rs(8'h08);
    mode(8'h50);
    touch(8'h01);
    chk(irqOutLow, 1'b1, "two single");
    touch(8'h03);
    chk(irqOutLow, 1'b0, "two pair");
    touch(8'h07);
    rs(8'h03);
    mode(8'h00);
    wr(tsil_pkg::ADDR_MASK, 8'h0F);
    touch(8'hF0);
    chk(irqOutLow, 1'b1, "masked irq");
    chk(sampleEnable, 8'hFF, "masked sampled");
    rs(8'h00);
    wr(tsil_pkg::ADDR_MASK, 8'hFF);
    mode(8'h04);
    touch(8'h03);
    touch(8'h01);
    rs(8'h03);
    rs(8'h01);
    wr(tsil_pkg::ADDR_CONFIG, 8'h20);
    wr(tsil_pkg::ADDR_MASK, 8'h0F);
    chk(sampleEnable, 8'h0F, "skip");
    wr(tsil_pkg::ADDR_MASK, 8'hFF);
    chk(fastStart, 8'hF0, "new fast");
    wr(tsil_pkg::ADDR_COMMAND, tsil_pkg::CMD_SLEEP);
    chk({oscEnable, regulatorEnable, analogEnable}, 3'h0, "asleep");
    bus(1'b0, tsil_pkg::ADDR_MASK, 32'h0, 33'h0FF);
    wr(tsil_pkg::ADDR_COMMAND, tsil_pkg::CMD_WAKE);
    chk(fastStart, 8'hFF, "restart");
    sleepPin <= 1'b1;
    repeat (5) @(posedge clk);
    chk(regulatorEnable, 1'b0, "pin sleep");
    sleepPin <= 1'b0;
    repeat (5) @(posedge clk);
    chk(regulatorEnable, 1'b1, "pin wake");
    chk(outHigh == 0, 1'b1, "alone out");
    wr(tsil_pkg::ADDR_CONFIG, 8'h01);
    repeat (40) @(posedge clk);
    chk(outHigh != 0, 1'b1, "primary out");
    wr(tsil_pkg::ADDR_CONFIG, 8'h02);
    t0 = ticks;
    repeat (40) @(posedge clk);
    chk({oscEnable, ticks > t0}, 2'h1, "secondary");
    report_and_stop();
  end
endmodule : tb_tsil_core
